// >>> verilog/stretcher_pkg.sv
// Constants, register map and carrier types of the six-phase bit stretcher.
// Assumes a single 25 MHz system clock and a plain strobe-style register port.
package stretcher_pkg;

	// =========================================================
	// Timing
	localparam int CLK_PERIOD_NS    = 40;
	localparam int SAMPLE_DELAY_NS  = 200;
	localparam int SAMPLE_DELAY_CYC = (SAMPLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PHASES           = 6;

	// =========================================================
	// Register offsets
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] LOSS_OFS   = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	localparam logic [7:0] MASK_OFS   = 8'h0c;
	localparam logic [7:0] STATE_OFS  = 8'h10;

	// =========================================================
	// Field positions
	localparam int STATE_CNT_LSB = 6;
	localparam int STATE_INH_BIT = 9;
	localparam int EV_INH_ON     = 0;
	localparam int EV_INH_OFF    = 1;
	localparam int EV_BRACKET    = 2;
	localparam int EV_W          = 3;

	// =========================================================
	// Reset values
	localparam logic [15:0]     LOSS_LIMIT_RST = 16'h0040;
	localparam logic [EV_W-1:0] MASK_RST       = 3'h0;
	localparam logic [2:0]      COUNTER_RST    = 3'h0;

	// =========================================================
	// Types
	typedef enum logic [1:0] {
		MODE_48_CHANNEL,
		INTERLEAVED_MODE,
		SEPARATED_MODE,
		REPEATER_MODE
	} opMode_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wrData;
		logic        wrStrobe;
		logic        rdStrobe;
	} regReq_t;

endpackage : stretcher_pkg

// >>> verilog/read_in_cell.sv
// One read-in gate with its storage flip-flop.
// Assumes tick is a one-cycle sampling pulse on clk_sys.
`timescale 1ns/1ps
module read_in_cell (
	input  wire logic clk_sys,
	input  wire logic arst_n,
	input  wire logic active,
	input  wire logic phaseA,
	input  wire logic phaseB,
	input  wire logic tick,
	input  wire logic pcmTrue,
	input  wire logic pcmComp,
	output logic      stored,
	output logic      gateOpen
);
	logic setN;
	logic resetN;

	// =========================================================
	// Gate
	assign gateOpen = active & phaseA & phaseB;
	// Closed gate drives ones so the edge changes nothing
	assign setN     = gateOpen ? ~pcmTrue : 1'b1;
	assign resetN   = gateOpen ? ~pcmComp : 1'b1;

	// =========================================================
	// Storage
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			stored <= 1'b0;
		end else if (tick) begin
			if (!setN) begin
				stored <= 1'b1;
			end else if (!resetN) begin
				stored <= 1'b0;
			end
		end
	end

	// =========================================================
	// Checks
	cell_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(tick && !gateOpen) |=> $stable(stored))
		else $error("store changed while its gate was closed");
	cell_load_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(tick && gateOpen) |=> (stored == $past(pcmTrue)))
		else $error("store did not load the current bit");

endmodule : read_in_cell

// >>> verilog/bit_stretcher.sv
// Six-phase bit stretcher: stores a serial stream across six flip-flops.
// Assumes pcmIn and timIn are asynchronous pins; timIn is far slower than clk_sys.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module bit_stretcher #(
	parameter int IDLE_W = 16
) (
	input  wire logic                   clk_sys,
	input  wire logic                   arst_n,
	input  wire logic                   pcmIn,
	input  wire logic                   timIn,
	input  wire stretcher_pkg::regReq_t busReq,
	output logic [31:0]                 rdData,
	output logic [5:0]                  storedBits,
	output logic                        firstStoredBit,
	output logic                        bracketPulse,
	output logic                        inhibit,
	output logic                        bypassData,
	output logic                        irq
);

	// =========================================================
	// Declarations
	logic                                timSync1_reg;
	logic                                timSync2_reg;
	logic                                timSync3_reg;
	logic                                pcmSync1_reg;
	logic                                pcmSync2_reg;
	logic                                pcmSync3_reg;
	logic                                timRise;
	logic                                pcmEdge;
	logic                                pcmTrue;
	logic                                pcmComp;
	logic [2:0]                          delayCnt_reg;
	logic                                tick;
	logic [2:0]                          cnt_reg;
	logic [2:0]                          cnt_next;
	logic                                s0;
	logic                                s1;
	logic                                s2;
	logic [5:0]                          phA;
	logic [5:0]                          phB;
	logic [5:0]                          gateOpen;
	logic                                active;
	stretcher_pkg::opMode_t              mode_reg;
	logic [IDLE_W-1:0]                   lossLimit_reg;
	logic [IDLE_W-1:0]                   dataIdle_reg;
	logic [IDLE_W-1:0]                   timIdle_reg;
	logic                                inhPrev_reg;
	logic [stretcher_pkg::EV_W-1:0]      status_reg;
	logic [stretcher_pkg::EV_W-1:0]      status_next;
	logic [stretcher_pkg::EV_W-1:0]      mask_reg;
	logic [stretcher_pkg::EV_W-1:0]      events;
	logic                                statusRead;

	localparam int DLY_M1 = stretcher_pkg::SAMPLE_DELAY_CYC - 1;

	// =========================================================
	// Input synchronisers
	// Both pins are foreign to clk_sys; third stage only feeds edge finders
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			timSync1_reg <= 1'b0;
			timSync2_reg <= 1'b0;
			timSync3_reg <= 1'b0;
		end else begin
			timSync1_reg <= timIn;
			timSync2_reg <= timSync1_reg;
			timSync3_reg <= timSync2_reg;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pcmSync1_reg <= 1'b0;
			pcmSync2_reg <= 1'b0;
			pcmSync3_reg <= 1'b0;
		end else begin
			pcmSync1_reg <= pcmIn;
			pcmSync2_reg <= pcmSync1_reg;
			pcmSync3_reg <= pcmSync2_reg;
		end
	end

	assign timRise = timSync2_reg & ~timSync3_reg;
	assign pcmEdge = pcmSync2_reg ^ pcmSync3_reg;
	assign pcmTrue = pcmSync2_reg;
	assign pcmComp = ~pcmSync2_reg;

	// =========================================================
	// Sampling clock
	// Delay keeps the sampling instant away from data transitions
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			delayCnt_reg <= 3'h0;
		end else if (timRise) begin
			delayCnt_reg <= 3'(stretcher_pkg::SAMPLE_DELAY_CYC);
		end else if (delayCnt_reg != 3'h0) begin
			delayCnt_reg <= delayCnt_reg - 3'h1;
		end
	end

	assign tick = (delayCnt_reg == 3'h1);

	// =========================================================
	// Divide-by-six counter
	assign s0 = cnt_reg[0];
	assign s1 = cnt_reg[1];
	assign s2 = cnt_reg[2];
	assign active = (mode_reg == stretcher_pkg::INTERLEAVED_MODE) ||
		(mode_reg == stretcher_pkg::SEPARATED_MODE);

	// Feedback gate also steers the two illegal codes back into the ring
	assign cnt_next = {s1, s0, ~s2 & ~(s1 & ~s0)};

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= stretcher_pkg::COUNTER_RST;
		end else if (!active) begin
			cnt_reg <= stretcher_pkg::COUNTER_RST;
		end else if (tick) begin
			cnt_reg <= cnt_next;
		end
	end

	// =========================================================
	// Read-in gates and stores
	// Each gate decodes a distinct adjacent pair of counter phases
	assign phA = {~s1, ~s0, s2, s1, s0, ~s0};
	assign phB = {s2, s1, s0, ~s2, ~s1, ~s2};

	genvar gi;
	generate
		for (gi = 0; gi < stretcher_pkg::PHASES; gi++) begin : gCell
			read_in_cell uCell (
				.clk_sys  (clk_sys),
				.arst_n   (arst_n),
				.active   (active),
				.phaseA   (phA[gi]),
				.phaseB   (phB[gi]),
				.tick     (tick),
				.pcmTrue  (pcmTrue),
				.pcmComp  (pcmComp),
				.stored   (storedBits[gi]),
				.gateOpen (gateOpen[gi])
			);
		end
	endgenerate

	assign firstStoredBit = storedBits[0];

	// =========================================================
	// Bracket pulse and repeater bypass
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			bracketPulse <= 1'b0;
		end else begin
			bracketPulse <= tick & gateOpen[0];
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			bypassData <= 1'b0;
		end else begin
			bypassData <= (mode_reg == stretcher_pkg::REPEATER_MODE) & pcmTrue;
		end
	end

	// =========================================================
	// Loss-of-activity detector
	// Idle counters saturate so a dead line never wraps back to active
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			dataIdle_reg <= '0;
		end else if (pcmEdge) begin
			dataIdle_reg <= '0;
		end else if (dataIdle_reg != '1) begin
			dataIdle_reg <= dataIdle_reg + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			timIdle_reg <= '0;
		end else if (timRise) begin
			timIdle_reg <= '0;
		end else if (timIdle_reg != '1) begin
			timIdle_reg <= timIdle_reg + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			inhibit     <= 1'b0;
			inhPrev_reg <= 1'b0;
		end else begin
			inhibit     <= (dataIdle_reg >= lossLimit_reg) ||
				(timIdle_reg >= lossLimit_reg);
			inhPrev_reg <= inhibit;
		end
	end

	// =========================================================
	// Control registers
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			mode_reg      <= stretcher_pkg::MODE_48_CHANNEL;
			lossLimit_reg <= IDLE_W'(stretcher_pkg::LOSS_LIMIT_RST);
			mask_reg      <= stretcher_pkg::MASK_RST;
		end else if (busReq.wrStrobe) begin
			case (busReq.addr)
				stretcher_pkg::CTRL_OFS: begin
					mode_reg <= stretcher_pkg::opMode_t'(busReq.wrData[1:0]);
				end
				stretcher_pkg::LOSS_OFS: begin
					lossLimit_reg <= busReq.wrData[IDLE_W-1:0];
				end
				stretcher_pkg::MASK_OFS: begin
					mask_reg <= busReq.wrData[stretcher_pkg::EV_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// =========================================================
	// Interrupt status
	assign events[stretcher_pkg::EV_INH_ON]  = inhibit & ~inhPrev_reg;
	assign events[stretcher_pkg::EV_INH_OFF] = ~inhibit & inhPrev_reg;
	assign events[stretcher_pkg::EV_BRACKET] = bracketPulse;
	assign statusRead = busReq.rdStrobe && (busReq.addr == stretcher_pkg::STATUS_OFS);
	// New event wins over the clear-on-read in the same cycle
	assign status_next = (statusRead ? '0 : status_reg) | events;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			status_reg <= '0;
			irq        <= 1'b0;
		end else begin
			status_reg <= status_next;
			irq        <= |(status_next & mask_reg);
		end
	end

	// =========================================================
	// Read port
	// Data stand one cycle only; unmapped offsets read zero
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rdData <= 32'h0;
		end else if (busReq.rdStrobe) begin
			case (busReq.addr)
				stretcher_pkg::CTRL_OFS:   rdData <= {30'h0, mode_reg};
				stretcher_pkg::LOSS_OFS:   rdData <= 32'(lossLimit_reg);
				stretcher_pkg::STATUS_OFS: rdData <= 32'(status_reg);
				stretcher_pkg::MASK_OFS:   rdData <= 32'(mask_reg);
				stretcher_pkg::STATE_OFS: begin
					rdData <= 32'({inhibit, cnt_reg, storedBits});
				end
				default:                   rdData <= 32'h0;
			endcase
		end else begin
			rdData <= 32'h0;
		end
	end

	// =========================================================
	// Checks
	logic [5:0] gateRot;
	assign gateRot = {gateOpen[4:0], gateOpen[5]};

	one_gate_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		active |-> $onehot(gateOpen))
		else $error("not exactly one read-in gate open");

	gate_rotate_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(tick && active && $past(active)) |=> ((gateOpen == $past(gateRot)) || !active))
		else $error("read-in gates left their rotating order");

	// Ticks since the first gate loaded; parked high while idle
	logic [2:0] restCnt_reg;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			restCnt_reg <= 3'h7;
		end else if (!active) begin
			restCnt_reg <= 3'h7;
		end else if (tick && gateOpen[0]) begin
			restCnt_reg <= 3'h0;
		end else if (tick && restCnt_reg != 3'h7) begin
			restCnt_reg <= restCnt_reg + 3'h1;
		end
	end

	gate_rest_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(tick && gateOpen[0]) |-> (restCnt_reg >= 3'h5))
		else $error("first gate reopened within five periods");

	idle_48_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(mode_reg == stretcher_pkg::MODE_48_CHANNEL) |-> (gateOpen == 6'h00))
		else $error("read-in logic active in 48-channel mode");

	repeater_pass_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(mode_reg == stretcher_pkg::REPEATER_MODE) |=> (bypassData == $past(pcmTrue)))
		else $error("repeater bypass does not follow input");

	bracket_load_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(tick && gateOpen[0]) |=> (bracketPulse && firstStoredBit == $past(pcmTrue)))
		else $error("bracket pulse not with first store load");

	sample_delay_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		timRise ##1 (!timRise [*1]) |-> ##[DLY_M1:DLY_M1] (tick || timRise))
		else $error("sampling pulse not at the fixed delay");

	loss_inhibit_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		((dataIdle_reg >= lossLimit_reg) || (timIdle_reg >= lossLimit_reg)) |=> inhibit)
		else $error("inhibit missing on lost activity");

	release_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		((dataIdle_reg < lossLimit_reg) && (timIdle_reg < lossLimit_reg)) |=> !inhibit)
		else $error("inhibit held while both inputs active");

	counter_legal_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(cnt_reg == 3'h2 || cnt_reg == 3'h5) |-> ##[1:300] (cnt_reg == 3'h0 ||
			cnt_reg == 3'h1 || cnt_reg == 3'h3 || cnt_reg == 3'h4 ||
			cnt_reg == 3'h6 || cnt_reg == 3'h7))
		else $error("counter stuck in illegal code");

	full_cycle_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
		(tick && gateOpen[5] && active) ##[1:20] bracketPulse);
	inhibit_on_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
		$rose(inhibit));
	repeater_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
		(mode_reg == stretcher_pkg::REPEATER_MODE) && $rose(bypassData));
	irq_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
		$rose(irq));

endmodule : bit_stretcher

// >>> bench/downstream_model.sv
// Downstream readout model: rebuilds the stream from the six stores.
// Assumes one timing period is PERIOD_CYC system clocks, phase-locked to the bracket.
`timescale 1ns/1ps
module downstream_model #(
	parameter int PERIOD_CYC = 8
) (
	input  wire logic       clk_sys,
	input  wire logic       arst_n,
	input  wire logic [5:0] storedBits,
	input  wire logic       bracketPulse,
	input  wire logic       inhibit,
	output logic            rebuiltBit,
	output logic            rebuiltValid
);
	logic [2:0] slotReg;
	logic [3:0] waitReg;

	// =========================================================
	// Readout, one store per timing period
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			slotReg      <= 3'h6;
			waitReg      <= 4'h0;
			rebuiltBit   <= 1'b0;
			rebuiltValid <= 1'b0;
		end else begin
			rebuiltValid <= 1'b0;
			if (inhibit) begin
				slotReg <= 3'h6;
			end else if (bracketPulse) begin
				rebuiltBit   <= storedBits[0];
				rebuiltValid <= 1'b1;
				slotReg      <= 3'h1;
				waitReg      <= 4'h1;
			end else if (slotReg < 3'h6) begin
				if (waitReg == 4'(PERIOD_CYC)) begin
					rebuiltBit   <= storedBits[slotReg];
					rebuiltValid <= 1'b1;
					slotReg      <= slotReg + 3'h1;
					waitReg      <= 4'h1;
				end else begin
					waitReg <= waitReg + 4'h1;
				end
			end
		end
	end
endmodule : downstream_model

// >>> bench/tb_six_phase_bit_stretcher.sv
// Self-checking bench for the six-phase bit stretcher.
// Assumes a 320 ns timing pin, free of the system clock's phase.
`timescale 1ns/1ps
module tb_six_phase_bit_stretcher;
	localparam logic [31:0] PATTERN = 32'h6b4d_2c95;
	localparam int          LIMIT   = 20000;
	logic                   clk_sys = 1'b0;
	logic                   arst_n  = 1'b0;
	logic                   pcmIn   = 1'b0;
	logic                   timIn   = 1'b0;
	stretcher_pkg::regReq_t busReq  = '0;
	logic [31:0]            rdData;
	logic [5:0]             storedBits;
	logic                   firstStoredBit, bracketPulse, inhibit, bypassData, irq;
	logic                   rebuiltBit, rebuiltValid;
	logic                   timStall = 1'b0, dataStall = 1'b0, spaceOn = 1'b0;
	int                     n_errors = 0, checks_done = 0, cycles = 0, lastBr = 0, brCount = 0;
	int                     bitIdx = 0;
	bit                     sent[$], rebuilt[$];

	bit_stretcher dut (.clk_sys(clk_sys), .arst_n(arst_n), .pcmIn(pcmIn), .timIn(timIn),
		.busReq(busReq), .rdData(rdData), .storedBits(storedBits),
		.firstStoredBit(firstStoredBit), .bracketPulse(bracketPulse),
		.inhibit(inhibit), .bypassData(bypassData), .irq(irq));
	downstream_model partner (.clk_sys(clk_sys), .arst_n(arst_n), .storedBits(storedBits),
		.bracketPulse(bracketPulse), .inhibit(inhibit), .rebuiltBit(rebuiltBit),
		.rebuiltValid(rebuiltValid));

	// =========================================================
	// Clocks and pin stimulus
	always #20 clk_sys = ~clk_sys;
	initial begin
		#13;
		forever begin
			#160;
			timIn = timStall ? 1'b0 : ~timIn;
		end
	end
	// New bit mid-period so sampling never meets an edge
	always @(negedge timIn) begin
		if (!dataStall) begin
			pcmIn = PATTERN[bitIdx % 32];
			sent.push_back(PATTERN[bitIdx % 32]);
			bitIdx++;
		end
	end

	// =========================================================
	// Checking helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : close_out
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		busReq <= '{addr: a, wrData: d, wrStrobe: 1'b1, rdStrobe: 1'b0};
		@(posedge clk_sys);
		busReq <= '{addr: a, wrData: d, wrStrobe: 1'b0, rdStrobe: 1'b0};
	endtask : wr
	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		busReq <= '{addr: a, wrData: 32'h0, wrStrobe: 1'b0, rdStrobe: 1'b1};
		@(posedge clk_sys);
		busReq <= '{addr: a, wrData: 32'h0, wrStrobe: 1'b0, rdStrobe: 1'b0};
		@(negedge clk_sys);
		if (exp !== 32'hffff_ffff) check(rdData, exp);
	endtask : rdChk
	// Rebuilt stream must be an unbroken run of the sent stream
	task automatic streamChk();
		int  o, i;
		bit  hit, ok;
		hit = 1'b0;
		for (o = 0; o + rebuilt.size() <= sent.size(); o++) begin
			ok = 1'b1;
			for (i = 0; i < rebuilt.size(); i++) if (rebuilt[i] != sent[o + i]) ok = 1'b0;
			if (ok) hit = 1'b1;
		end
		check(32'(rebuilt.size() >= 30), 32'h1);
		check(32'(hit), 32'h1);
	endtask : streamChk

	// =========================================================
	// Monitors and timeout
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == LIMIT) begin
			n_errors++;
			$display("CHECK FAILED at %0t: run did not finish", $time);
			close_out();
		end
	end
	always @(negedge clk_sys) begin
		if (rebuiltValid) rebuilt.push_back(rebuiltBit);
		if (bracketPulse) begin
			brCount++;
			// Reads of stale stores left from the previous mode are dropped
			if (spaceOn && lastBr == 0) rebuilt.delete();
			if (spaceOn) check(firstStoredBit, pcmIn);
			if (spaceOn && lastBr != 0) check(32'(cycles - lastBr), 32'd48);
			lastBr = cycles;
		end
	end

	// =========================================================
	// Tests
	initial begin
		int         m, k;
		logic [5:0] held;
		repeat (16) @(posedge clk_sys);
		arst_n <= 1'b1;
		rdChk(stretcher_pkg::CTRL_OFS, 32'h0);
		rdChk(stretcher_pkg::LOSS_OFS, 32'h0000_0040);
		rdChk(stretcher_pkg::MASK_OFS, 32'h0);
		rdChk(8'h20, 32'h0);
		wr(stretcher_pkg::STATE_OFS, 32'h3ff);
		rdChk(stretcher_pkg::STATE_OFS, 32'h0);
		wr(stretcher_pkg::LOSS_OFS, 32'h30);
		rdChk(stretcher_pkg::LOSS_OFS, 32'h30);
		$display("test registers done");
		repeat (100) @(posedge clk_sys);
		check(storedBits, 6'h0);
		check(brCount, 32'h0);
		$display("test idle mode done");
		wr(stretcher_pkg::MASK_OFS, 32'h4);
		for (m = 1; m <= 2; m++) begin
			wr(stretcher_pkg::CTRL_OFS, 32'h0);
			rdChk(stretcher_pkg::STATUS_OFS, 32'hffff_ffff);
			rebuilt.delete();
			lastBr = 0;
			spaceOn = 1'b1;
			wr(stretcher_pkg::CTRL_OFS, 32'(m));
			repeat (330) @(posedge clk_sys);
			@(negedge clk_sys);
			spaceOn = 1'b0;
			check(irq, 1'b1);
			streamChk();
			rdChk(stretcher_pkg::STATUS_OFS, 32'h4);
			$display("test active mode %0d done", m);
		end
		wr(stretcher_pkg::CTRL_OFS, 32'h3);
		@(negedge clk_sys);
		held = storedBits;
		for (k = 0; k < 8; k++) begin
			@(posedge timIn);
			@(negedge clk_sys);
			check(bypassData, pcmIn);
		end
		check(storedBits, held);
		$display("test repeater done");
		wr(stretcher_pkg::MASK_OFS, 32'h3);
		for (k = 0; k < 2; k++) begin
			rdChk(stretcher_pkg::STATUS_OFS, 32'hffff_ffff);
			if (k == 0) timStall = 1'b1;
			else dataStall = 1'b1;
			for (m = 0; m < 300 && inhibit !== 1'b1; m++) @(negedge clk_sys);
			check(inhibit, 1'b1);
			@(negedge clk_sys);
			check(irq, 1'b1);
			rdChk(stretcher_pkg::STATUS_OFS, 32'h1);
			timStall = 1'b0;
			dataStall = 1'b0;
			for (m = 0; m < 300 && inhibit !== 1'b0; m++) @(negedge clk_sys);
			check(inhibit, 1'b0);
			rdChk(stretcher_pkg::STATUS_OFS, 32'h2);
			repeat (2) @(negedge clk_sys);
			check(irq, 1'b0);
			$display("test loss %0d done", k);
		end
		close_out();
	end
endmodule : tb_six_phase_bit_stretcher
